/* File: logic/pdc_defs.svh */
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define PDC_ADDR_W          10
`define PDC_NUM_REGS        6
`define PDC_OFS_PLL_CTRL    10'h010
`define PDC_OFS_REF_LOW     10'h011
`define PDC_OFS_REF_HIGH    10'h012
`define PDC_OFS_SWALLOW     10'h013
`define PDC_OFS_MAIN_LOW    10'h014
`define PDC_OFS_MAIN_HIGH   10'h015

// ****************************************
// Reset values and implemented-bit masks
// ****************************************
`define PDC_RST_PLL_CTRL    8'h7d
`define PDC_RST_REF_LOW     8'h01
`define PDC_RST_REF_HIGH    8'h00
`define PDC_RST_SWALLOW     8'h00
`define PDC_RST_MAIN_LOW    8'h03
`define PDC_RST_MAIN_HIGH   8'h00
`define PDC_MSK_PLL_CTRL    8'hff
`define PDC_MSK_REF_LOW     8'hff
`define PDC_MSK_REF_HIGH    8'h3f
`define PDC_MSK_SWALLOW     8'h3f
`define PDC_MSK_MAIN_LOW    8'hff
`define PDC_MSK_MAIN_HIGH   8'h1f

// ****************************************
// Field positions in the PLL control register, the divider high registers and the swallow register
// ****************************************
`define PDC_POL_BIT         7
`define PDC_CUR_MSB         6
`define PDC_CUR_LSB         4
`define PDC_MODE_MSB        3
`define PDC_MODE_LSB        2
`define PDC_PWR_MSB         1
`define PDC_PWR_LSB         0
`define PDC_REF_HIGH_MSB    5
`define PDC_SWALLOW_MSB     5
`define PDC_MAIN_HIGH_MSB   4

`endif

/* File: logic/pdc_pkg.sv */
`default_nettype none
package pdc_pkg;

   // ****************************************
   // Charge pump and PLL power encodings
   // ****************************************
   typedef enum logic [1:0] {
      PDC_PUMP_HIZ    = 2'h0,
      PDC_PUMP_UP     = 2'h1,
      PDC_PUMP_DOWN   = 2'h2,
      PDC_PUMP_NORMAL = 2'h3
   } pdc_pump_e;

   typedef enum logic [1:0] {
      PDC_PWR_RUN        = 2'h0,
      PDC_PWR_ASYNC_DOWN = 2'h1,
      PDC_PWR_UNUSED     = 2'h2,
      PDC_PWR_SYNC_DOWN  = 2'h3
   } pdc_power_e;

endpackage : pdc_pkg
`default_nettype wire

/* File: logic/pdc_byte_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module pdc_byte_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] MASK      = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] q
);

   // ****************************************
   // Storage
   // ****************************************
   // Unimplemented bits never store, so they read back as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= RESET_VAL & MASK;
      end else if (wr_en) begin
         q <= wdata & MASK;
      end
   end

endmodule : pdc_byte_reg
`default_nettype wire

/* File: logic/pdc_pll_divider_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"
module pdc_pll_divider_regs (
   input  wire logic                    REF_CLK,
   input  wire logic                    ARST_N,
   input  wire logic [`PDC_ADDR_W-1:0]  REG_ADDR,
   input  wire logic [7:0]              REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   input  wire logic                    USE_INTERNAL_OSC,
   output var  logic [7:0]              REG_RDATA,
   output var  logic                    REG_RVALID,
   output logic                         PHASE_FREQ_DETECTOR_POLARITY,
   output logic [2:0]                   CHARGE_PUMP_CURRENT,
   output logic [1:0]                   CHARGE_PUMP_MODE,
   output logic [1:0]                   PLL_POWER_MODE,
   output logic [13:0]                  REF_DIVIDER,
   output logic [5:0]                   SWALLOW_COUNT,
   output logic [12:0]                  MAIN_COUNT,
   output var  logic                    PUMP_HIZ,
   output var  logic                    PUMP_SOURCE,
   output var  logic                    PUMP_SINK,
   output var  logic                    PLL_RUN,
   output var  logic                    PLL_ASYNC_DOWN,
   output var  logic                    PLL_SYNC_DOWN,
   output var  logic                    POLARITY_CONFLICT
);

   // ****************************************
   // Register table
   // ****************************************
   localparam int NREG = `PDC_NUM_REGS;
   localparam logic [`PDC_ADDR_W-1:0] OFFS [NREG] = '{
      `PDC_OFS_PLL_CTRL, `PDC_OFS_REF_LOW, `PDC_OFS_REF_HIGH,
      `PDC_OFS_SWALLOW, `PDC_OFS_MAIN_LOW, `PDC_OFS_MAIN_HIGH};
   localparam logic [7:0] RSTS [NREG] = '{
      `PDC_RST_PLL_CTRL, `PDC_RST_REF_LOW, `PDC_RST_REF_HIGH,
      `PDC_RST_SWALLOW, `PDC_RST_MAIN_LOW, `PDC_RST_MAIN_HIGH};
   localparam logic [7:0] MSKS [NREG] = '{
      `PDC_MSK_PLL_CTRL, `PDC_MSK_REF_LOW, `PDC_MSK_REF_HIGH,
      `PDC_MSK_SWALLOW, `PDC_MSK_MAIN_LOW, `PDC_MSK_MAIN_HIGH};

   logic [7:0] reg_q [NREG];
   logic [7:0] next_rdata;

   // ****************************************
   // One byte register per map entry
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         pdc_byte_reg #(
            .RESET_VAL (RSTS[gi]),
            .MASK      (MSKS[gi])
         ) u_reg (
            .clk    (REF_CLK),
            .arst_n (ARST_N),
            .wr_en  (REG_WR && (REG_ADDR == OFFS[gi])),
            .wdata  (REG_WDATA),
            .q      (reg_q[gi])
         );
      end
   endgenerate

   // ****************************************
   // Field outputs, taken straight from the register flops
   // ****************************************
   assign PHASE_FREQ_DETECTOR_POLARITY = reg_q[0][`PDC_POL_BIT];
   assign CHARGE_PUMP_CURRENT = reg_q[0][`PDC_CUR_MSB:`PDC_CUR_LSB];
   assign CHARGE_PUMP_MODE    = reg_q[0][`PDC_MODE_MSB:`PDC_MODE_LSB];
   assign PLL_POWER_MODE      = reg_q[0][`PDC_PWR_MSB:`PDC_PWR_LSB];
   // Divider words join only the defined fields, so stray writes to unused bits cannot leak in
   assign REF_DIVIDER   = {reg_q[2][`PDC_REF_HIGH_MSB:0], reg_q[1]};
   assign SWALLOW_COUNT = reg_q[3][`PDC_SWALLOW_MSB:0];
   assign MAIN_COUNT    = {reg_q[5][`PDC_MAIN_HIGH_MSB:0], reg_q[4]};

   // ****************************************
   // Read mux
   // ****************************************
   // Unmapped addresses read zero rather than holding stale data
   always_comb begin
      next_rdata = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (REG_ADDR == OFFS[i]) begin
            next_rdata = reg_q[i];
         end
      end
   end

   // Read data is captured on the strobe and held until the next read
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= next_rdata;
         end
      end
   end

   // ****************************************
   // Charge pump mode decode
   // ****************************************
   // Registered so every strobe to the analog side comes off a flop, one cycle after the field
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PUMP_HIZ    <= 1'b0;
         PUMP_SOURCE <= 1'b0;
         PUMP_SINK   <= 1'b0;
      end else begin
         PUMP_HIZ    <= 1'b0;
         PUMP_SOURCE <= 1'b0;
         PUMP_SINK   <= 1'b0;
         case (pdc_pkg::pdc_pump_e'(CHARGE_PUMP_MODE))
            pdc_pkg::PDC_PUMP_HIZ:    PUMP_HIZ    <= 1'b1;
            pdc_pkg::PDC_PUMP_UP:     PUMP_SOURCE <= 1'b1;
            pdc_pkg::PDC_PUMP_DOWN:   PUMP_SINK   <= 1'b1;
            pdc_pkg::PDC_PUMP_NORMAL: PUMP_HIZ    <= 1'b0;
            default:                  PUMP_HIZ    <= 1'b1;
         endcase
      end
   end

   // ****************************************
   // PLL power decode
   // ****************************************
   // The unused code keeps the loop off; running it there would be a guess
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PLL_RUN        <= 1'b0;
         PLL_ASYNC_DOWN <= 1'b1;
         PLL_SYNC_DOWN  <= 1'b0;
      end else begin
         PLL_RUN        <= 1'b0;
         PLL_ASYNC_DOWN <= 1'b0;
         PLL_SYNC_DOWN  <= 1'b0;
         case (pdc_pkg::pdc_power_e'(PLL_POWER_MODE))
            pdc_pkg::PDC_PWR_RUN:        PLL_RUN        <= 1'b1;
            pdc_pkg::PDC_PWR_ASYNC_DOWN: PLL_ASYNC_DOWN <= 1'b1;
            pdc_pkg::PDC_PWR_SYNC_DOWN:  PLL_SYNC_DOWN  <= 1'b1;
            pdc_pkg::PDC_PWR_UNUSED:     PLL_RUN        <= 1'b0;
            default:                     PLL_ASYNC_DOWN <= 1'b1;
         endcase
      end
   end

   // ****************************************
   // Polarity check
   // ****************************************
   // Hardware only flags the bad setting; keeping it right is up to software
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         POLARITY_CONFLICT <= 1'b0;
      end else begin
         POLARITY_CONFLICT <= USE_INTERNAL_OSC && PHASE_FREQ_DETECTOR_POLARITY;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_pump_hiz_mode: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (CHARGE_PUMP_MODE == 2'h0) |=> (PUMP_HIZ && !PUMP_SOURCE && !PUMP_SINK))
      else $error("Pump mode 00 did not give high impedance");

   a_pump_normal_mode: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (CHARGE_PUMP_MODE == 2'h3) |=> !(PUMP_HIZ || PUMP_SOURCE || PUMP_SINK))
      else $error("Normal pump mode drove a forced strobe");

   a_pll_power_run: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (PLL_POWER_MODE == 2'h0) ##1 (PLL_POWER_MODE == 2'h0) |-> PLL_RUN && !PLL_ASYNC_DOWN)
      else $error("Power code 00 did not run the loop");

   a_pll_power_down: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (PLL_POWER_MODE == 2'h1) |=> (PLL_ASYNC_DOWN && !PLL_RUN && !PLL_SYNC_DOWN))
      else $error("Power code 01 did not give asynchronous power-down");

   a_pump_up_mode: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (CHARGE_PUMP_MODE == 2'h1) |=> (PUMP_SOURCE && !PUMP_HIZ && !PUMP_SINK))
      else $error("Pump mode 01 did not give constant pump up");

   a_pump_down_mode: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (CHARGE_PUMP_MODE == 2'h2) |=> (PUMP_SINK && !PUMP_HIZ && !PUMP_SOURCE))
      else $error("Pump mode 10 did not give constant pump down");

   a_pll_sync_down: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (PLL_POWER_MODE == 2'h3) |=> (PLL_SYNC_DOWN && !PLL_RUN && !PLL_ASYNC_DOWN))
      else $error("Power code 11 did not give synchronous power-down");

   a_pll_unused_off: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (PLL_POWER_MODE == 2'h2) |=> !(PLL_RUN || PLL_ASYNC_DOWN || PLL_SYNC_DOWN))
      else $error("Unused power code drove a power decode");

   a_ref_low_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == `PDC_OFS_REF_LOW) |=> (REF_DIVIDER[7:0] == $past(REG_WDATA)))
      else $error("Reference divider low byte not written");

   a_ref_high_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == `PDC_OFS_REF_HIGH) |=> (REF_DIVIDER[13:8] == $past(REG_WDATA[5:0])))
      else $error("Reference divider upper bits not written");

   a_swallow_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == `PDC_OFS_SWALLOW) |=> (SWALLOW_COUNT == $past(REG_WDATA[5:0])))
      else $error("Swallow count not written");

   a_main_low_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == `PDC_OFS_MAIN_LOW) |=> (MAIN_COUNT[7:0] == $past(REG_WDATA)))
      else $error("Main count low byte not written");

   a_main_high_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == `PDC_OFS_MAIN_HIGH) |=> (MAIN_COUNT[12:8] == $past(REG_WDATA[4:0])))
      else $error("Main count upper bits not written");

   a_polarity_flag: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (USE_INTERNAL_OSC && PHASE_FREQ_DETECTOR_POLARITY) |=> POLARITY_CONFLICT)
      else $error("Negative polarity with internal oscillator not flagged");

   a_unused_read_zero: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_RD && (REG_ADDR == `PDC_OFS_REF_HIGH || REG_ADDR == `PDC_OFS_SWALLOW))
      |=> (REG_RVALID && REG_RDATA[7:6] == 2'h0))
      else $error("Unused divider bits read non-zero");

   a_unused_main_zero: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (REG_RD && REG_ADDR == `PDC_OFS_MAIN_HIGH) |=> (REG_RVALID && REG_RDATA[7:5] == 3'h0))
      else $error("Unused main count bits read non-zero");

endmodule : pdc_pll_divider_regs
`default_nettype wire

/* File: sim/tb_pdc_pll_divider_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"
module tb_pdc_pll_divider_regs;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        ref_clk;
   logic        arst_n;
   logic [9:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        use_int_osc;
   logic [7:0]  rdata;
   logic        rvalid;
   logic        pol;
   logic [2:0]  cur;
   logic [1:0]  mode;
   logic [1:0]  pwr;
   logic [13:0] ref_div;
   logic [5:0]  swallow;
   logic [12:0] main_cnt;
   logic        hiz, src, snk, run, adown, sdown, conflict;
   logic [7:0]  shadow [0:5];
   int          bad_count;
   int          compares;
   int          cycles;

   pdc_pll_divider_regs dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .USE_INTERNAL_OSC(use_int_osc), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .PHASE_FREQ_DETECTOR_POLARITY(pol), .CHARGE_PUMP_CURRENT(cur), .CHARGE_PUMP_MODE(mode),
      .PLL_POWER_MODE(pwr), .REF_DIVIDER(ref_div), .SWALLOW_COUNT(swallow), .MAIN_COUNT(main_cnt),
      .PUMP_HIZ(hiz), .PUMP_SOURCE(src), .PUMP_SINK(snk), .PLL_RUN(run), .PLL_ASYNC_DOWN(adown),
      .PLL_SYNC_DOWN(sdown), .POLARITY_CONFLICT(conflict));

   // ****************************************
   // Clock and hang guard
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Ceiling is many times the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end

   // ****************************************
   // Expectation helpers and checks
   // ****************************************
   // Implemented bits of each register, unused ones read as zero
   function automatic logic [7:0] msk(input int i);
      case (i)
         2, 3:    msk = 8'h3f;
         5:       msk = 8'h1f;
         default: msk = 8'hff;
      endcase
   endfunction : msk

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Writes land on the rising edge between two falling edges
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      if (a >= `PDC_OFS_PLL_CTRL && a <= `PDC_OFS_MAIN_HIGH) shadow[a - `PDC_OFS_PLL_CTRL] = d & msk(int'(a[2:0]));
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk("rvalid", 16'h1, {15'h0, rvalid});
      chk("rdata", {8'h0, exp}, {8'h0, rdata});
      @(negedge ref_clk);
      chk("rvalid_low", 16'h0, {15'h0, rvalid});
   endtask : rd

   // Decodes trail the fields by a cycle, so call after one idle cycle
   task automatic check_fields();
      chk("polarity", {15'h0, shadow[0][7]}, {15'h0, pol});
      chk("current", {13'h0, shadow[0][6:4]}, {13'h0, cur});
      chk("pump_mode", {14'h0, shadow[0][3:2]}, {14'h0, mode});
      chk("power_mode", {14'h0, shadow[0][1:0]}, {14'h0, pwr});
      chk("pump_decode", {13'h0, shadow[0][3:2] == 2'h0, shadow[0][3:2] == 2'h1, shadow[0][3:2] == 2'h2},
          {13'h0, hiz, src, snk});
      chk("power_decode", {13'h0, shadow[0][1:0] == 2'h0, shadow[0][1:0] == 2'h1, shadow[0][1:0] == 2'h3},
          {13'h0, run, adown, sdown});
      chk("conflict", {15'h0, use_int_osc & shadow[0][7]}, {15'h0, conflict});
      chk("ref_divider", {2'h0, shadow[2][5:0], shadow[1]}, {2'h0, ref_div});
      chk("swallow", {10'h0, shadow[3][5:0]}, {10'h0, swallow});
      chk("main_count", {3'h0, shadow[5][4:0], shadow[4]}, {3'h0, main_cnt});
   endtask : check_fields

   task automatic read_all();
      for (int i = 0; i < 6; i++) rd(`PDC_OFS_PLL_CTRL + 10'(i), shadow[i]);
   endtask : read_all

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [7:0] d;
      logic [9:0] ua;
      int         i;
      void'($urandom(32'h7239));
      shadow = '{8'h7d, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
      {arst_n, reg_wr, reg_rd, use_int_osc, reg_addr, reg_wdata} = '0;
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b1;
      check_fields();
      read_all();
      $display("test reset_values done");
      // Every pump mode against every power code, field visible at once
      for (int c = 0; c < 16; c++) begin
         use_int_osc = 1'($urandom);
         d = {1'($urandom), 3'($urandom), 4'(c)};
         wr(`PDC_OFS_PLL_CTRL, d);
         chk("mode_now", {12'h0, 4'(c)}, {12'h0, mode, pwr});
         @(negedge ref_clk);
         check_fields();
      end
      $display("test control_codes done");
      // All ones then all zeros probe the unused bits
      // An idle cycle between writes keeps the strobe from dropping and rising in one step
      for (int k = 0; k < 2; k++) begin
         for (int r = 1; r < 6; r++) begin
            wr(`PDC_OFS_PLL_CTRL + 10'(r), (k != 0) ? 8'h00 : 8'hff);
            @(negedge ref_clk);
         end
         check_fields();
         read_all();
      end
      $display("test boundaries done");
      repeat (40) begin
         i = $urandom_range(1, 5);
         wr(`PDC_OFS_PLL_CTRL + 10'(i), 8'($urandom));
         check_fields();
         i = $urandom_range(0, 5);
         rd(`PDC_OFS_PLL_CTRL + 10'(i), shadow[i]);
      end
      $display("test random_access done");
      // Unmapped places, one aliasing the control register in its low bits
      for (int k = 0; k < 4; k++) begin
         ua = (k == 0) ? 10'h016 : (k == 1) ? 10'h000 : (k == 2) ? 10'h3ff : 10'h210;
         wr(ua, 8'($urandom));
         rd(ua, 8'h00);
         check_fields();
      end
      $display("test unmapped done");
      // Reset in mid-run brings every register back to its default
      arst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      arst_n = 1'b1;
      shadow = '{8'h7d, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
      check_fields();
      read_all();
      $display("test mid_reset done");
      // Read and write together return the old value
      d = shadow[3];
      reg_addr = `PDC_OFS_SWALLOW;
      reg_wdata = 8'h2a;
      {reg_wr, reg_rd} = 2'b11;
      @(negedge ref_clk);
      {reg_wr, reg_rd} = 2'b00;
      shadow[3] = 8'h2a;
      chk("read_old", {8'h0, d}, {8'h0, rdata});
      check_fields();
      $display("test read_during_write done");
      print_verdict();
   end
endmodule : tb_pdc_pll_divider_regs
`default_nettype wire
